//--- logic/mso_params.svh
// constants of the motor status and output select block
// assumes a 250 MHz clock and a 32-bit register bus
`ifndef MSO_PARAMS_SVH
`define MSO_PARAMS_SVH

// timing
`define MSO_CLK_KHZ 250000
`define MSO_TRIP_HOLD_MS 200
`define MSO_TRIP_HOLD_CYCLES (`MSO_TRIP_HOLD_MS * `MSO_CLK_KHZ)

// widths
`define MSO_ADDR_W 8
`define MSO_ADC_W 12
`define MSO_SPD_W 16

// register byte offsets
`define MSO_OFS_CTRL 8'h00
`define MSO_OFS_LIMITS 8'h04
`define MSO_OFS_ISPEED 8'h08
`define MSO_OFS_TORQUE 8'h0C
`define MSO_OFS_MATCH 8'h10
`define MSO_OFS_RATIO 8'h14
`define MSO_OFS_STATUS 8'h18
`define MSO_OFS_CMDSPD 8'h1C
`define MSO_OFS_DISPLAY 8'h20
`define MSO_OFS_TLIM 8'h24

// control register fields
`define MSO_CTRL_SRC_BIT 0
`define MSO_CTRL_FUNC_LSB 4
`define MSO_CTRL_POL_BIT 8
`define MSO_CTRL_MON_LSB 12
`define MSO_CTRL_PCNT_LSB 16
`define MSO_CTRL_MASK 32'h0007_7171

// reset values
`define MSO_CTRL_RST 32'h0000_0000
`define MSO_LIMITS_RST 32'h0BB8_0000
`define MSO_ISPEED_RST 16'h0000
`define MSO_TORQUE_RST 8'h64
`define MSO_MATCH_RST 16'h0032
`define MSO_RATIO_RST 32'h0001_0001

// scaling
`define MSO_FULL_PCT 8'h64
`define MSO_DISPLAY_MAX 17'h1869F
`define MSO_RESP_OKAY 2'h0
`define MSO_RESP_SLVERR 2'h2

`endif

//--- logic/mso_pkg.sv
// types of the motor status and output select block
// assumes mso_params.svh is on the include path
`include "mso_params.svh"

package mso_pkg;

    typedef enum logic [2:0] {
        MSO_FN_TRIP = 3'h0,
        MSO_FN_ARRIVAL = 3'h1,
        MSO_FN_RUN = 3'h2,
        MSO_FN_FREE = 3'h3,
        MSO_FN_CCW = 3'h4,
        MSO_FN_CW = 3'h5,
        MSO_FN_OVERLOAD = 3'h6,
        MSO_FN_PULSE = 3'h7
    } mso_func_t;

    typedef enum logic [2:0] {
        MSO_MON_SPEED = 3'h0,
        MSO_MON_TORQUE = 3'h1,
        MSO_MON_AVGLOAD = 3'h2,
        MSO_MON_CMD = 3'h3,
        MSO_MON_DCV = 3'h4
    } mso_mon_t;

    typedef enum logic {MSO_WR_IDLE = 1'b0, MSO_WR_RESP = 1'b1} mso_wr_t;
    typedef enum logic {MSO_RD_IDLE = 1'b0, MSO_RD_DATA = 1'b1} mso_rd_t;

    typedef struct packed {
        logic trip_fault;
        logic reset_req;
        logic running;
        logic free_run;
        logic run_ccw;
        logic run_cw;
        logic cmd_ccw;
        logic edge_tick;
        logic [`MSO_SPD_W-1:0] act_speed;
        logic [7:0] load_pct;
        logic [15:0] torque;
        logic [15:0] avg_load;
        logic [15:0] dc_volt;
        logic [`MSO_ADC_W-1:0] analog_code;
    } mso_motor_in_t;

    typedef struct packed {
        mso_wr_t wr_state;
        logic awready;
        logic wready;
        logic aw_done;
        logic w_done;
        logic [`MSO_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        mso_rd_t rd_state;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [31:0] limits;
        logic [`MSO_SPD_W-1:0] ispeed;
        logic [7:0] torque;
        logic [15:0] match;
        logic [31:0] ratio;
        logic trip;
        logic out;
        logic pulse_level;
        logic [4:0] edge_cnt;
        logic arrival;
        logic overload;
        logic [`MSO_SPD_W-1:0] cmd_speed;
        logic [15:0] torque_lim;
        logic [16:0] display;
    } mso_state_t;

endpackage

//--- logic/mso_hold_timer.sv
// one-shot hold detector: fires once an enable has stayed high for CYCLES clocks
// assumes enable is synchronous to clk
`timescale 1ns/1ps

module mso_hold_timer #(
    parameter int unsigned CYCLES = 50000000,
    parameter int unsigned CNT_W = $clog2(CYCLES + 1)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // hold request and result
    input wire logic en,
    output logic done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic fired;
        logic done;
    } mso_hold_state_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    mso_hold_state_t s;
    mso_hold_state_t n;

    always_comb begin
        n = s;
        n.done = 1'b0;
        if (!en) begin
            n.cnt = '0;
            n.fired = 1'b0;
        end else if (!s.fired) begin
            if (s.cnt == LAST) begin
                n.fired = 1'b1;
                n.done = 1'b1;
            end else begin
                n.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done = s.done;
endmodule

//--- logic/mso_lin_map.sv
// maps an analogue speed code linearly between a lower and an upper speed
// assumes code zero stands for 0 V and all ones for 5 V
`timescale 1ns/1ps

module mso_lin_map #(
    parameter int unsigned CODE_W = 12,
    parameter int unsigned SPD_W = 16
) (
    // analogue code and end points
    input wire logic [CODE_W-1:0] code,
    input wire logic [SPD_W-1:0] lower,
    input wire logic [SPD_W-1:0] upper,
    // commanded speed
    output logic [SPD_W-1:0] speed
);
    logic [SPD_W-1:0] span;
    logic [SPD_W+CODE_W-1:0] prod;

    always_comb begin
        span = (upper > lower) ? (upper - lower) : '0;
        prod = span * code;
        if (code == '1) begin
            speed = upper;
        end else begin
            speed = lower + prod[SPD_W+CODE_W-1:CODE_W];
        end
    end
endmodule

//--- logic/mso_status_top.sv
// motor status, limit and output select logic with an AXI4-Lite register slave
// assumes motor inputs are synchronous to REF_CLK and the bus master follows AXI4-Lite
`timescale 1ns/1ps
`include "mso_params.svh"

// What this block does
// R1 - the controller holds the trip-reset request at least 0.2 s
// R2 - trip-reset acts only while a trip is latched, otherwise ignored
// R3 - analogue source: zero input commands the lower speed limit
// R4 - analogue source: full-scale input commands the upper speed limit
// R5 - stored internal speed never exceeds the upper speed limit
// R6 - torque limit is a percentage, 100 meaning rated torque
// R7 - one selected status source drives the output terminal
// R8 - overload source is active while load exceeds 100 percent
// R9 - polarity setting inverts the output terminal
// R10 - arrival is active while speed error is below the matching range
// R11 - arrival is suppressed while rotation direction is changing
// R12 - pulse source gives 1, 2, 3, 4, 6, 8, 12 or 24 pulses per turn
// R13 - display shows the monitor quantity selected, five digits
// R14 - speed display is scaled by numerator over denominator
// R15 - software should not set the matching range too small
// R16 - analogue inputs between the ends interpolate linearly
module mso_status_top #(
    parameter int unsigned TRIP_HOLD_CYCLES = `MSO_TRIP_HOLD_CYCLES,
    parameter logic [15:0] RATED_TORQUE = 16'h03E8,
    parameter logic [4:0] EDGES_PER_HALF_TURN = 5'h18
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // register bus write
    input wire logic [`MSO_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // register bus read
    input wire logic [`MSO_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // motor side
    input wire mso_pkg::mso_motor_in_t MOTOR_IN,
    output logic STATUS_OUT,
    output logic TRIP_ACTIVE,
    output logic [`MSO_SPD_W-1:0] CMD_SPEED,
    output logic [15:0] TORQUE_LIMIT,
    output logic [16:0] DISPLAY_VALUE
);
    mso_pkg::mso_state_t s;
    mso_pkg::mso_state_t n;
    mso_pkg::mso_func_t func;
    mso_pkg::mso_mon_t mon;
    logic [`MSO_SPD_W-1:0] map_speed;
    logic [`MSO_SPD_W-1:0] upper;
    logic [`MSO_SPD_W-1:0] lower;
    logic [`MSO_SPD_W-1:0] speed_err;
    logic hold_en;
    logic hold_done;
    logic dir_changing;
    logic src;
    logic [4:0] half;
    logic [31:0] spd_scaled;
    logic [23:0] tq_scaled;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign lower = s.limits[15:0];
    assign upper = s.limits[31:16];
    assign func = mso_pkg::mso_func_t'(s.ctrl[`MSO_CTRL_FUNC_LSB +: 3]);
    assign mon = mso_pkg::mso_mon_t'(s.ctrl[`MSO_CTRL_MON_LSB +: 3]);
    assign hold_en = MOTOR_IN.reset_req & s.trip; // [R2]

    mso_hold_timer #(
        .CYCLES(TRIP_HOLD_CYCLES)
    ) i_mso_hold_timer (
        .clk(REF_CLK),
        .rstn(RSTN),
        .en(hold_en),
        .done(hold_done)
    );

    mso_lin_map #(
        .CODE_W(`MSO_ADC_W),
        .SPD_W(`MSO_SPD_W)
    ) i_mso_lin_map (
        .code(MOTOR_IN.analog_code),
        .lower(lower),
        .upper(upper),
        .speed(map_speed)
    );

    // read data multiplexer
    always_comb begin
        rd_resp = `MSO_RESP_OKAY;
        case (ARADDR)
            `MSO_OFS_CTRL: rd_word = s.ctrl;
            `MSO_OFS_LIMITS: rd_word = s.limits;
            `MSO_OFS_ISPEED: rd_word = {16'h0000, s.ispeed};
            `MSO_OFS_TORQUE: rd_word = {24'h000000, s.torque};
            `MSO_OFS_MATCH: rd_word = {16'h0000, s.match};
            `MSO_OFS_RATIO: rd_word = s.ratio;
            `MSO_OFS_STATUS: rd_word = {27'h0000000, s.pulse_level, s.overload, s.arrival, s.out, s.trip};
            `MSO_OFS_CMDSPD: rd_word = {16'h0000, s.cmd_speed};
            `MSO_OFS_DISPLAY: rd_word = {15'h0000, s.display};
            `MSO_OFS_TLIM: rd_word = {16'h0000, s.torque_lim};
            default: begin
                rd_word = 32'h0000_0000;
                rd_resp = `MSO_RESP_SLVERR;
            end
        endcase
    end

    // speed error, direction change, pulse divider and scalers
    always_comb begin
        speed_err = (MOTOR_IN.act_speed > s.cmd_speed) ? (MOTOR_IN.act_speed - s.cmd_speed)
                                                       : (s.cmd_speed - MOTOR_IN.act_speed);
        dir_changing = (MOTOR_IN.run_ccw | MOTOR_IN.run_cw) & (MOTOR_IN.cmd_ccw != MOTOR_IN.run_ccw);
        case (s.ctrl[`MSO_CTRL_PCNT_LSB +: 3])
            3'h0: half = EDGES_PER_HALF_TURN;
            3'h1: half = 5'(EDGES_PER_HALF_TURN / 2);
            3'h2: half = 5'(EDGES_PER_HALF_TURN / 3);
            3'h3: half = 5'(EDGES_PER_HALF_TURN / 4);
            3'h4: half = 5'(EDGES_PER_HALF_TURN / 6);
            3'h5: half = 5'(EDGES_PER_HALF_TURN / 8);
            3'h6: half = 5'(EDGES_PER_HALF_TURN / 12);
            default: half = 5'(EDGES_PER_HALF_TURN / 24);
        endcase
        spd_scaled = (s.ratio[31:16] == 16'h0000) ? 32'h0000_0000
                                                  : (MOTOR_IN.act_speed * s.ratio[15:0]) / s.ratio[31:16]; // [R14]
        tq_scaled = (RATED_TORQUE * s.torque) / `MSO_FULL_PCT; // [R6]
        case (func)
            mso_pkg::MSO_FN_TRIP: src = s.trip;
            mso_pkg::MSO_FN_ARRIVAL: src = s.arrival;
            mso_pkg::MSO_FN_RUN: src = MOTOR_IN.running;
            mso_pkg::MSO_FN_FREE: src = MOTOR_IN.free_run;
            mso_pkg::MSO_FN_CCW: src = MOTOR_IN.run_ccw;
            mso_pkg::MSO_FN_CW: src = MOTOR_IN.run_cw;
            mso_pkg::MSO_FN_OVERLOAD: src = s.overload;
            mso_pkg::MSO_FN_PULSE: src = s.pulse_level;
            default: src = 1'b0;
        endcase // [R7]
    end

    // next state
    always_comb begin
        n = s;
        // write address and data, taken in either order
        if (s.awready && AWVALID) begin
            n.awready = 1'b0;
            n.aw_done = 1'b1;
            n.awaddr = AWADDR;
        end
        if (s.wready && WVALID) begin
            n.wready = 1'b0;
            n.w_done = 1'b1;
            n.wdata = WDATA;
            n.wstrb = WSTRB;
        end
        case (s.wr_state)
            mso_pkg::MSO_WR_IDLE: begin
                if (s.aw_done && s.w_done) begin
                    n.aw_done = 1'b0;
                    n.w_done = 1'b0;
                    n.bvalid = 1'b1;
                    n.bresp = `MSO_RESP_OKAY;
                    n.wr_state = mso_pkg::MSO_WR_RESP;
                    case (s.awaddr)
                        `MSO_OFS_CTRL: n.ctrl = merge(s.ctrl, s.wdata, s.wstrb) & `MSO_CTRL_MASK;
                        `MSO_OFS_LIMITS: n.limits = merge(s.limits, s.wdata, s.wstrb);
                        `MSO_OFS_ISPEED: n.ispeed = 16'(merge({16'h0000, s.ispeed}, s.wdata, s.wstrb));
                        `MSO_OFS_TORQUE: n.torque = 8'(merge({24'h000000, s.torque}, s.wdata, s.wstrb));
                        `MSO_OFS_MATCH: n.match = 16'(merge({16'h0000, s.match}, s.wdata, s.wstrb));
                        `MSO_OFS_RATIO: n.ratio = merge(s.ratio, s.wdata, s.wstrb);
                        `MSO_OFS_STATUS, `MSO_OFS_CMDSPD, `MSO_OFS_DISPLAY, `MSO_OFS_TLIM: n.bresp = `MSO_RESP_OKAY;
                        default: n.bresp = `MSO_RESP_SLVERR;
                    endcase
                end
            end
            mso_pkg::MSO_WR_RESP: begin
                if (BREADY) begin
                    n.bvalid = 1'b0;
                    n.awready = 1'b1;
                    n.wready = 1'b1;
                    n.wr_state = mso_pkg::MSO_WR_IDLE;
                end
            end
            default: n.wr_state = mso_pkg::MSO_WR_IDLE;
        endcase
        // read channel
        case (s.rd_state)
            mso_pkg::MSO_RD_IDLE: begin
                if (ARVALID) begin
                    n.arready = 1'b0;
                    n.rvalid = 1'b1;
                    n.rdata = rd_word;
                    n.rresp = rd_resp;
                    n.rd_state = mso_pkg::MSO_RD_DATA;
                end
            end
            mso_pkg::MSO_RD_DATA: begin
                if (RREADY) begin
                    n.rvalid = 1'b0;
                    n.arready = 1'b1;
                    n.rd_state = mso_pkg::MSO_RD_IDLE;
                end
            end
            default: n.rd_state = mso_pkg::MSO_RD_IDLE;
        endcase
        // internal speed held at or below the upper limit
        if (n.ispeed > n.limits[31:16]) begin
            n.ispeed = n.limits[31:16]; // [R5]
        end
        // commanded speed
        if (s.ctrl[`MSO_CTRL_SRC_BIT]) begin
            n.cmd_speed = map_speed; // [R3] [R4] [R16]
        end else begin
            n.cmd_speed = s.ispeed;
        end
        n.torque_lim = (tq_scaled > 24'h00FFFF) ? 16'hFFFF : tq_scaled[15:0]; // [R6]
        // trip latch, a new fault wins over the reset
        n.trip = MOTOR_IN.trip_fault | (s.trip & ~hold_done); // [R2]
        // pulse output, toggles every half period in motor edges
        if (MOTOR_IN.edge_tick) begin
            if (s.edge_cnt + 5'h01 >= half) begin
                n.edge_cnt = 5'h00;
                n.pulse_level = ~s.pulse_level; // [R12]
            end else begin
                n.edge_cnt = s.edge_cnt + 5'h01;
            end
        end
        n.arrival = (speed_err < s.match) & ~dir_changing; // [R10] [R11]
        n.overload = MOTOR_IN.load_pct > `MSO_FULL_PCT; // [R8]
        n.out = src ^ s.ctrl[`MSO_CTRL_POL_BIT]; // [R9]
        // monitor display
        case (mon)
            mso_pkg::MSO_MON_SPEED: n.display = (spd_scaled > 32'(`MSO_DISPLAY_MAX)) ? `MSO_DISPLAY_MAX
                                                                                       : spd_scaled[16:0];
            mso_pkg::MSO_MON_TORQUE: n.display = {1'b0, MOTOR_IN.torque};
            mso_pkg::MSO_MON_AVGLOAD: n.display = {1'b0, MOTOR_IN.avg_load};
            mso_pkg::MSO_MON_CMD: n.display = {1'b0, s.cmd_speed};
            mso_pkg::MSO_MON_DCV: n.display = {1'b0, MOTOR_IN.dc_volt};
            default: n.display = 17'h00000;
        endcase // [R13]
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.ctrl <= `MSO_CTRL_RST;
            s.limits <= `MSO_LIMITS_RST;
            s.ispeed <= `MSO_ISPEED_RST;
            s.torque <= `MSO_TORQUE_RST;
            s.match <= `MSO_MATCH_RST;
            s.ratio <= `MSO_RATIO_RST;
        end else begin
            s <= n;
        end
    end

    assign AWREADY = s.awready;
    assign WREADY = s.wready;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = s.arready;
    assign RVALID = s.rvalid;
    assign RDATA = s.rdata;
    assign RRESP = s.rresp;
    assign STATUS_OUT = s.out;
    assign TRIP_ACTIVE = s.trip;
    assign CMD_SPEED = s.cmd_speed;
    assign TORQUE_LIMIT = s.torque_lim;
    assign DISPLAY_VALUE = s.display;

    // checks
    property p_trip_clear_needs_hold;
        @(posedge REF_CLK) disable iff (!RSTN)
        RSTN && $fell(TRIP_ACTIVE) |-> $past(hold_done) && $past(hold_en, 2);
    endproperty
    a_trip_clear_needs_hold: assert property (p_trip_clear_needs_hold) else $error("trip cleared early"); // [R2]

    property p_zero_code;
        @(posedge REF_CLK) disable iff (!RSTN)
        (s.ctrl[`MSO_CTRL_SRC_BIT] && MOTOR_IN.analog_code == '0) |=> CMD_SPEED == $past(lower);
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero input did not give lower limit"); // [R3]

    property p_full_code;
        @(posedge REF_CLK) disable iff (!RSTN)
        (s.ctrl[`MSO_CTRL_SRC_BIT] && MOTOR_IN.analog_code == '1) |=> CMD_SPEED == $past(upper);
    endproperty
    a_full_code: assert property (p_full_code) else $error("full input did not give upper limit"); // [R4]

    property p_ispeed_clamped;
        @(posedge REF_CLK) disable iff (!RSTN)
        s.ispeed <= upper;
    endproperty
    a_ispeed_clamped: assert property (p_ispeed_clamped) else $error("internal speed above upper limit"); // [R5]

    property p_full_torque;
        @(posedge REF_CLK) disable iff (!RSTN)
        (RSTN && s.torque == `MSO_FULL_PCT) |=> TORQUE_LIMIT == RATED_TORQUE;
    endproperty
    a_full_torque: assert property (p_full_torque) else $error("100 percent is not rated torque"); // [R6]

    sequence s_run_selected;
        func == mso_pkg::MSO_FN_RUN && !s.ctrl[`MSO_CTRL_POL_BIT];
    endsequence
    property p_run_routed;
        @(posedge REF_CLK) disable iff (!RSTN)
        s_run_selected |=> STATUS_OUT == $past(MOTOR_IN.running);
    endproperty
    a_run_routed: assert property (p_run_routed) else $error("run state not routed to output"); // [R7]

    property p_overload_out;
        @(posedge REF_CLK) disable iff (!RSTN)
        (func == mso_pkg::MSO_FN_OVERLOAD && !s.ctrl[`MSO_CTRL_POL_BIT] && MOTOR_IN.load_pct > `MSO_FULL_PCT)
        |=> ##1 STATUS_OUT;
    endproperty
    a_overload_out: assert property (p_overload_out) else $error("overload not shown"); // [R8]

    property p_polarity;
        @(posedge REF_CLK) disable iff (!RSTN)
        (func == mso_pkg::MSO_FN_RUN && s.ctrl[`MSO_CTRL_POL_BIT]) |=> STATUS_OUT == !$past(MOTOR_IN.running);
    endproperty
    a_polarity: assert property (p_polarity) else $error("output not inverted"); // [R9]

    property p_arrival;
        @(posedge REF_CLK) disable iff (!RSTN)
        (RSTN && speed_err < s.match && !dir_changing) |=> s.arrival;
    endproperty
    a_arrival: assert property (p_arrival) else $error("arrival missing inside matching range"); // [R10]

    property p_arrival_dir;
        @(posedge REF_CLK) disable iff (!RSTN)
        dir_changing |=> !s.arrival;
    endproperty
    a_arrival_dir: assert property (p_arrival_dir) else $error("arrival during direction change"); // [R11]

    property p_pulse_24;
        @(posedge REF_CLK) disable iff (!RSTN)
        (s.ctrl[`MSO_CTRL_PCNT_LSB +: 3] == 3'h7 && MOTOR_IN.edge_tick) |=> s.pulse_level != $past(s.pulse_level);
    endproperty
    a_pulse_24: assert property (p_pulse_24) else $error("pulse did not toggle on each edge"); // [R12]

    property p_display_dcv;
        @(posedge REF_CLK) disable iff (!RSTN)
        (mon == mso_pkg::MSO_MON_DCV) |=> DISPLAY_VALUE == {1'b0, $past(MOTOR_IN.dc_volt)};
    endproperty
    a_display_dcv: assert property (p_display_dcv) else $error("display does not show dc voltage"); // [R13]

    property p_display_ratio;
        @(posedge REF_CLK) disable iff (!RSTN)
        (RSTN && mon == mso_pkg::MSO_MON_SPEED && s.ratio == `MSO_RATIO_RST)
        |=> DISPLAY_VALUE == {1'b0, $past(MOTOR_IN.act_speed)};
    endproperty
    a_display_ratio: assert property (p_display_ratio) else $error("unit ratio changed speed display"); // [R14]

    property p_between_limits;
        @(posedge REF_CLK) disable iff (!RSTN)
        (s.ctrl[`MSO_CTRL_SRC_BIT] && lower <= upper) |=> CMD_SPEED >= $past(lower) && CMD_SPEED <= $past(upper);
    endproperty
    a_between_limits: assert property (p_between_limits) else $error("analogue command outside limits"); // [R16]
endmodule

//--- test/mso_ctl_model.sv
// external controller model: makes motor edge ticks and counts output pulses
// assumes one clock shared with the block
`timescale 1ns/1ps
module mso_ctl_model (
    // clock and tick enable
    input wire logic clk,
    input wire logic en,
    // motor tick and output terminal
    output logic tick,
    input wire logic status,
    output int rises
);
    logic [1:0] div = 2'h0;
    logic last = 1'b0;
    initial tick = 1'b0;
    initial rises = 0;
    // one tick every four clocks, rising edges of the terminal counted
    always @(posedge clk) begin
        div <= en ? div + 2'h1 : 2'h0;
        tick <= en && div == 2'h3;
        last <= status;
        if (status && !last) rises <= rises + 1;
    end
endmodule

//--- test/motor_status_output_select_tb_top.sv
// testbench of the motor status and output select block
// assumes the design files and mso_params.svh are compiled first
`timescale 1ns/1ps
`include "mso_params.svh"
module motor_status_output_select_tb_top;
    logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, sout, trip, tick, pen = 1'b0;
    logic [1:0] bresp, rresp;
    logic [15:0] cspd, tlim;
    logic [16:0] disp;
    int rises, error_cnt = 0, num_checks = 0;
    int cnt[8] = '{1, 2, 3, 4, 6, 8, 12, 24};
    mso_pkg::mso_motor_in_t mi = '0, mo;
    always #2 clk = ~clk;
    always_comb begin
        mo = mi;
        mo.edge_tick = tick;
    end
    mso_status_top #(.TRIP_HOLD_CYCLES(20)) i_mso_status_top (.REF_CLK(clk), .RSTN(rstn), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .MOTOR_IN(mo), .STATUS_OUT(sout),
        .TRIP_ACTIVE(trip), .CMD_SPEED(cspd), .TORQUE_LIMIT(tlim), .DISPLAY_VALUE(disp));
    mso_ctl_model i_mso_ctl_model (.clk(clk), .en(pen), .tick(tick), .status(sout), .rises(rises));
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tmo(input int n);
        if (n >= 50) begin
            error_cnt++;
            $display("mismatch at %0t: bus timeout", $time);
            conclude;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        tmo(n);
        chk(bresp, a > `MSO_OFS_TLIM ? `MSO_RESP_SLVERR : `MSO_RESP_OKAY);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        tmo(n);
        chk({rresp, rdata}, exp);
    endtask
    task t_regs;
        rd(`MSO_OFS_LIMITS, {2'h0, `MSO_LIMITS_RST});
        rd(`MSO_OFS_TLIM, 34'h3E8);
        rd(8'h28, {2'h2, 32'h0});
        wr(8'h28, 32'h0);
        wr(`MSO_OFS_ISPEED, 32'hFFFF);
        rd(`MSO_OFS_ISPEED, 34'h0BB8);
        wr(`MSO_OFS_TORQUE, 32'h32);
        rd(`MSO_OFS_TLIM, 34'h1F4);
        chk(tlim, 34'h1F4);
        $display("registers done");
    endtask
    task t_trip;
        mi.reset_req <= 1'b1;
        repeat (15) @(posedge clk);
        mi.trip_fault <= 1'b1;
        @(posedge clk);
        mi.trip_fault <= 1'b0;
        repeat (10) @(posedge clk);
        chk(trip, 1'b1);
        chk(sout, 1'b1);
        mi.reset_req <= 1'b0;
        @(posedge clk);
        mi.reset_req <= 1'b1;
        repeat (25) @(posedge clk);
        chk(trip, 1'b0);
        mi.reset_req <= 1'b0;
        $display("trip done");
    endtask
    task t_sel;
        logic [4:0] m;
        for (int f = 2; f < 7; f++) begin
            for (int v = 0; v < 4; v++) begin
                wr(`MSO_OFS_CTRL, 32'(f << 4 | v[1] << 8));
                m = (5'h1 << (f - 2)) ^ {5{v[0]}};
                {mi.run_cw, mi.run_ccw, mi.free_run, mi.running} <= m[3:0];
                mi.load_pct <= m[4] ? 8'h65 : 8'h64;
                repeat (3) @(posedge clk);
                chk(sout, m[f - 2] ^ v[1]);
            end
        end
        mi.act_speed <= 16'h0100;
        wr(`MSO_OFS_RATIO, 32'h0002_0003);
        wr(`MSO_OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk(disp, 17'h00180);
        mi.torque <= 16'h0011;
        mi.avg_load <= 16'h0022;
        mi.dc_volt <= 16'h0044;
        for (int q = 1; q < 5; q++) begin
            wr(`MSO_OFS_CTRL, 32'(q << 12));
            repeat (3) @(posedge clk);
            chk(disp, q == 1 ? 17'h11 : q == 2 ? 17'h22 : q == 3 ? 17'hBB8 : 17'h44);
        end
        $display("select done");
    endtask
    task t_ana;
        wr(`MSO_OFS_CTRL, 32'h1);
        wr(`MSO_OFS_LIMITS, 32'h0F00_0100);
        for (int i = 0; i < 3; i++) begin
            mi.analog_code <= i == 0 ? 12'h000 : i == 1 ? 12'hFFF : 12'h800;
            repeat (3) @(posedge clk);
            chk(cspd, i == 0 ? 16'h0100 : i == 1 ? 16'h0F00 : 16'h0800);
        end
        wr(`MSO_OFS_CTRL, 32'h11);
        for (int j = 0; j < 3; j++) begin
            mi.act_speed <= j == 0 ? 16'h0831 : j == 1 ? 16'h0832 : 16'h0800;
            {mi.running, mi.run_ccw, mi.run_cw, mi.cmd_ccw} <= j == 2 ? 4'hB : 4'h8;
            repeat (4) @(posedge clk);
            chk(sout, j == 0);
        end
        $display("analogue done");
    endtask
    task t_pulse;
        int r0;
        pen <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(`MSO_OFS_CTRL, 32'(32'h70 | k << 16));
            repeat (192) @(posedge clk);
            r0 = rises;
            repeat (384) @(posedge clk);
            chk(34'(rises - r0), 34'(2 * cnt[k]));
        end
        pen <= 1'b0;
        $display("pulse done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_trip;
        t_sel;
        t_ana;
        t_pulse;
        conclude;
    end
endmodule
